//--- hw/pic_capture.sv
// pixel port capture and lookup request forming
// How it works
// - index, overlay select, blank and sync are registered together each rising clock edge.
// - a captured blank low forces the converters to the blanking level for that pixel.
// - while blank is low the index and overlay select do not reach the outputs.
// - the pedestal select picks 0 IRE when low and 7.5 IRE when high.
// - a captured sync low turns off the 40 IRE current step for that pixel.
// - sync removes only its own step and changes neither blanking nor colour source.
// - the captured index selects one of 256 main palette entries, bit 0 least significant.
// - the overlay select picks the palette, and the index is ignored for overlay colours.
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_capture
  import pic_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`PIC_INDEX_W-1:0] pixel_index_i,
  input wire logic [`PIC_OVL_W-1:0] overlay_select_i,
  input wire logic blank_n_i,
  input wire logic sync_n_i,
  input wire logic pedestal_sel_i,
  output logic pix_valid_o,
  input wire logic pix_ready_i,
  output logic [`PIC_SRC_W-1:0] pix_source_o,
  output logic [`PIC_INDEX_W-1:0] pix_index_o,
  output logic [`PIC_OVL_W-1:0] pix_overlay_o,
  output logic pix_blank_o,
  output logic pix_sync_off_o,
  output logic pix_pedestal_o,
  output logic overrun_o
);
  // request word: source, index, overlay, blank, sync off, pedestal
  localparam int WORD_W = `PIC_SRC_W + `PIC_INDEX_W + `PIC_OVL_W + 3;

  // pin synchronisers: first stage feeds only the second
  logic [`PIC_INDEX_W-1:0] idx_s1;
  logic [`PIC_INDEX_W-1:0] idx_s2;
  logic [`PIC_OVL_W-1:0] ovl_s1;
  logic [`PIC_OVL_W-1:0] ovl_s2;
  logic blank_n_s1;
  logic blank_n_s2;
  logic sync_n_s1;
  logic sync_n_s2;
  logic ped_s1;
  logic ped_s2;

  // captured pixel
  logic cap_valid;
  logic [`PIC_INDEX_W-1:0] cap_index;
  logic [`PIC_OVL_W-1:0] cap_overlay;
  logic cap_blank_n;
  logic cap_sync_n;
  logic cap_ped;

  // formed request
  pic_src_t next_source;
  logic [`PIC_INDEX_W-1:0] next_index;
  logic [`PIC_OVL_W-1:0] next_overlay;
  logic [WORD_W-1:0] next_word;
  logic [WORD_W-1:0] buf_word;
  logic buf_in_ready;
  logic overrun;

  // pick the colour source; blanking wins over everything
  function automatic pic_src_t pic_pick_source(input logic blank_n,
                                               input logic [`PIC_OVL_W-1:0] ovl);
    if (!blank_n) pic_pick_source = PIC_SRC_BLANK;
    else if (ovl == `PIC_OVL_MAIN) pic_pick_source = PIC_SRC_MAIN;
    else pic_pick_source = PIC_SRC_OVERLAY;
  endfunction

  // pack one request word, source in the top bits
  function automatic logic [WORD_W-1:0] pic_pack_word(input pic_src_t src,
                                                      input logic [`PIC_INDEX_W-1:0] idx,
                                                      input logic [`PIC_OVL_W-1:0] ovl,
                                                      input logic blank,
                                                      input logic sync_off,
                                                      input logic ped);
    pic_pack_word = {src, idx, ovl, blank, sync_off, ped};
  endfunction

  // index pins, two flops before use
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      idx_s1 <= `PIC_INDEX_RST;
      idx_s2 <= `PIC_INDEX_RST;
    end else begin
      idx_s1 <= pixel_index_i;
      idx_s2 <= idx_s1;
    end
  end

  // overlay select pins, two flops before use
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovl_s1 <= `PIC_OVL_RST;
      ovl_s2 <= `PIC_OVL_RST;
    end else begin
      ovl_s1 <= overlay_select_i;
      ovl_s2 <= ovl_s1;
    end
  end

  // blank pin; resets low so stale colour never leaves after reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      blank_n_s1 <= `PIC_BLANK_N_RST;
      blank_n_s2 <= `PIC_BLANK_N_RST;
    end else begin
      blank_n_s1 <= blank_n_i;
      blank_n_s2 <= blank_n_s1;
    end
  end

  // sync pin; resets high so no false sync step
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_n_s1 <= `PIC_SYNC_N_RST;
      sync_n_s2 <= `PIC_SYNC_N_RST;
    end else begin
      sync_n_s1 <= sync_n_i;
      sync_n_s2 <= sync_n_s1;
    end
  end

  // pedestal pin, two flops before use
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ped_s1 <= `PIC_PED_RST;
      ped_s2 <= `PIC_PED_RST;
    end else begin
      ped_s1 <= pedestal_sel_i;
      ped_s2 <= ped_s1;
    end
  end

  // a pixel is captured on every edge once out of reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_valid <= 1'b0;
    end else begin
      cap_valid <= 1'b1;
    end
  end

  // all five captured signals land in one edge so they stay aligned
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_index <= `PIC_INDEX_RST;
      cap_overlay <= `PIC_OVL_RST;
      cap_blank_n <= `PIC_BLANK_N_RST;
      cap_sync_n <= `PIC_SYNC_N_RST;
      cap_ped <= `PIC_PED_RST;
    end else begin
      cap_index <= idx_s2;
      cap_overlay <= ovl_s2;
      cap_blank_n <= blank_n_s2;
      cap_sync_n <= sync_n_s2;
      cap_ped <= ped_s2;
    end
  end

  // form the request; index and overlay zeroed when unused
  always_comb begin
    next_source = pic_pick_source(cap_blank_n, cap_overlay);
    next_index = 8'h00;
    next_overlay = 4'h0;
    case (next_source)
      PIC_SRC_MAIN: begin
        next_index = cap_index;
      end
      PIC_SRC_OVERLAY: begin
        next_overlay = cap_overlay;
      end
      PIC_SRC_BLANK: begin
        next_index = `PIC_INDEX_RST;
        next_overlay = `PIC_OVL_RST;
      end
      default: begin
        next_index = `PIC_INDEX_RST;
        next_overlay = `PIC_OVL_RST;
      end
    endcase
    // sync only adds its own bit, source untouched
    next_word = pic_pack_word(next_source, next_index, next_overlay, ~cap_blank_n,
                              ~cap_sync_n, cap_ped);
  end

  // pixels keep coming; a full buffer drops one and flags it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun <= 1'b0;
    end else begin
      overrun <= cap_valid && !buf_in_ready;
    end
  end
  // registered flag, high one cycle per dropped pixel
  assign overrun_o = overrun;

  pic_skid_buffer #(
    .WIDTH(WORD_W)
  ) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .in_valid_i(cap_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(next_word),
    .out_valid_o(pix_valid_o),
    .out_ready_i(pix_ready_i),
    .out_data_o(buf_word)
  );

  // unpack the buffered word: colour request fields
  assign pix_source_o = buf_word[WORD_W-1 -: `PIC_SRC_W];
  assign pix_index_o = buf_word[WORD_W-1-`PIC_SRC_W -: `PIC_INDEX_W];
  assign pix_overlay_o = buf_word[`PIC_POS_OVL +: `PIC_OVL_W];

  // converter controls, one bit each
  assign pix_blank_o = buf_word[`PIC_POS_BLANK];
  assign pix_sync_off_o = buf_word[`PIC_POS_SYNC_OFF];
  assign pix_pedestal_o = buf_word[`PIC_POS_PED];
endmodule

//--- hw/pic_regs.svh
// constants for the pixel input capture block
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH
`define PIC_INDEX_W 8
`define PIC_OVL_W 4
`define PIC_BUF_DEPTH 2
`define PIC_OVL_MAIN 4'h0
`define PIC_SRC_W 2
// reset levels of the pin stages and the captured pixel
`define PIC_INDEX_RST 8'h00
`define PIC_OVL_RST 4'h0
`define PIC_BLANK_N_RST 1'b0
`define PIC_SYNC_N_RST 1'b1
`define PIC_PED_RST 1'b0
// bit positions of the low fields in the request word
`define PIC_POS_PED 0
`define PIC_POS_SYNC_OFF 1
`define PIC_POS_BLANK 2
`define PIC_POS_OVL 3
`endif

//--- hw/pic_pkg.sv
// types for the pixel input capture block
package pic_pkg;
  // colour source for one pixel
  typedef enum logic [1:0] {
    PIC_SRC_MAIN = 2'b00,
    PIC_SRC_OVERLAY = 2'b01,
    PIC_SRC_BLANK = 2'b10
  } pic_src_t;
endpackage

//--- hw/pic_skid_buffer.sv
// two-entry valid/ready buffer for formed pixel words
`timescale 1ns/1ps
`include "pic_regs.svh"
module pic_skid_buffer #(
  parameter int WIDTH = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // handshakes are combinational, data leaves from flip-flops
  assign in_ready_o = (count != 2'(`PIC_BUF_DEPTH)); // ignores a same-edge pop: short path
  assign out_valid_o = (count != 2'h0);
  assign out_data_o = mem[rd_ptr];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // storage, written by index
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem[0] <= '0;
      mem[1] <= '0;
    end else if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end
endmodule

//--- tb/pic_ctrl_model.sv
// graphics controller model: sync strobe toward the capture pins
`timescale 1ns/1ps
module pic_ctrl_model (
  input wire logic blank_n_i,
  input wire logic sync_req_n_i,
  output logic sync_n_o
);
  // a sync request outside blanking is withheld, as the controller must
  assign sync_n_o = sync_req_n_i | blank_n_i;
endmodule

//--- tb/pic_capture_properties.sv
// port assertions for the pixel capture block
`timescale 1ns/1ps
module pic_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic pix_valid_o,
  input wire logic pix_ready_i,
  input wire logic [1:0] pix_source_o,
  input wire logic [7:0] pix_index_o,
  input wire logic [3:0] pix_overlay_o,
  input wire logic pix_blank_o,
  input wire logic overrun_o
);
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // six stalled edges overfill two entries even from empty
  sequence stall_s;
    !pix_ready_i [*6];
  endsequence
  blank_src_a: assert property (pix_valid_o && pix_blank_o |-> pix_source_o == 2'h2)
    else $error("blank source wrong");
  blank_mute_a: assert property (pix_valid_o && pix_blank_o |->
    {pix_index_o, pix_overlay_o} == 12'h000) else $error("blank word has data");
  ovl_pick_a: assert property (pix_valid_o && pix_source_o == 2'h1 |->
    pix_index_o == 8'h00 && pix_overlay_o != 4'h0) else $error("overlay word bad");
  main_pick_a: assert property (pix_valid_o && pix_source_o == 2'h0 |->
    pix_overlay_o == 4'h0 && !pix_blank_o) else $error("main word bad");
  word_hold_a: assert property (pix_valid_o && !pix_ready_i |=>
    pix_valid_o && $stable({pix_source_o, pix_index_o, pix_overlay_o, pix_blank_o}))
    else $error("word moved");
  overrun_flag_a: assert property (stall_s |=> overrun_o)
    else $error("no overrun");
  overrun_cause_a: assert property (overrun_o |->
    !($past(pix_ready_i) && $past(pix_ready_i, 2))) else $error("odd overrun");
  reset_quiet_a: assert property ($fell(rst_i) |-> !pix_valid_o && !overrun_o)
    else $error("word after reset");
endmodule
bind pic_capture pic_chk u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .pix_valid_o(pix_valid_o),
  .pix_ready_i(pix_ready_i),
  .pix_source_o(pix_source_o),
  .pix_index_o(pix_index_o),
  .pix_overlay_o(pix_overlay_o),
  .pix_blank_o(pix_blank_o),
  .overrun_o(overrun_o)
);

//--- tb/pic_capture_tb.sv
// self-checking bench for the pixel capture block
`timescale 1ns/1ps
module pic_capture_tb;
  import pic_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ready = 1'b1;
  logic ped = 1'b0;
  logic blank_n = 1'b0;
  logic sync_req_n = 1'b1;
  logic [7:0] idx = 8'h00;
  logic [3:0] ovl = 4'h0;
  logic [31:0] seed = 32'h0000_06ef;
  logic sync_n, valid, overrun;
  wire [16:0] word;
  logic [16:0] exp_q[$];
  int mismatches = 0;
  int total_checks = 0;
  int drops = 0;
  bit locked = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  pic_ctrl_model u_ctrl (.blank_n_i(blank_n), .sync_req_n_i(sync_req_n), .sync_n_o(sync_n));
  pic_capture DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pixel_index_i(idx),
    .overlay_select_i(ovl), .blank_n_i(blank_n), .sync_n_i(sync_n), .pedestal_sel_i(ped),
    .pix_valid_o(valid), .pix_ready_i(ready), .pix_source_o(word[16:15]),
    .pix_index_o(word[14:7]), .pix_overlay_o(word[6:3]), .pix_blank_o(word[2]),
    .pix_sync_off_o(word[1]), .pix_pedestal_o(word[0]), .overrun_o(overrun));
  function automatic logic [31:0] xs(logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // blanking wins over overlay, overlay over index; sync only adds its flag
  function automatic logic [16:0] form(logic [7:0] i, logic [3:0] o, logic b_n, s_n, p);
    if (!b_n) return {PIC_SRC_BLANK, 12'h000, 1'b1, !s_n, p};
    if (o == 4'h0) return {PIC_SRC_MAIN, i, 4'h0, 1'b0, !s_n, p};
    return {PIC_SRC_OVERLAY, 8'h00, o, 1'b0, !s_n, p};
  endfunction
  task automatic check_val(logic [16:0] got, logic [16:0] want);
    total_checks++;
    if (got !== want) begin
      mismatches++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic check_count(int got, int want);
    total_checks++;
    if (got != want) begin
      mismatches++;
      $display("MISMATCH %0t count %0d want %0d", $time, got, want);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // pixels 150..169 repeat one value, so any dropped note is interchangeable
  task automatic pixel(int n);
    @(negedge sys_clk_i);
    ready = !(n >= 156 && n < 166);
    if (n < 150 || n >= 170) begin
      seed = xs(seed);
      {sync_req_n, blank_n, idx, ovl, ped} = n ? seed[15:1] : 15'h7fe0;
    end
    #1;
    exp_q.push_back(form(idx, ovl, blank_n, sync_n, ped));
  endtask
  // reset leftovers are skipped until the first note shows up
  always @(negedge sys_clk_i) begin
    #2;
    if (overrun === 1'b1 && exp_q.size() > 1) begin
      exp_q.delete(1);
      drops++;
    end
    if (valid === 1'b1 && ready && exp_q.size() > 0) begin
      locked |= word === exp_q[0];
      if (locked) check_val(word, exp_q.pop_front());
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge sys_clk_i);
    for (int n = 0; n < 400; n++) pixel(n);
    repeat (10) @(negedge sys_clk_i);
    // ten stalled edges drop nine pixels (the first one fills the buffer) and the release edge drops one more
    check_count(drops, 32'h0000_000a);
    // every note met its word, so a stuck or never-locked run fails
    check_count(exp_q.size(), 32'h0000_0000);
    complete_run();
  end
  initial begin
    #30000;
    mismatches++;
    complete_run();
  end
endmodule
